/* dsac_core.sv */
// Acquisition, antenna diversity and PN correlator logic of the baseband receiver.
`timescale 1ns/1ps
`default_nettype none

module dsac_core
  import dsac_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Register port.
  input wire dsac_bus_t bus,
  output logic [7:0] rd_data,
  // Baseband samples at two per chip.
  input wire dsac_sample_t sample_in,
  input wire logic sample_valid,
  // Receiver status and data.
  output logic antenna_sel,
  output logic carrier_sense_out,
  output logic coherent_mode,
  output logic data_valid,
  output logic rx_bit,
  output logic rx_bit_strobe,
  // Transmit spreading set-up.
  output logic [15:0] tx_spread_seq,
  output logic [1:0] tx_chip_len
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rxlen;
    logic [7:0] txlen;
    logic [15:0] txseq;
    logic [15:0] rxseq;
    logic [15:0] bthr;
    logic [15:0] pthr;
    dsac_sample_t [31:0] hist;
    logic [4:0] samp;
    logic [4:0] pos;
    logic [4:0] pk_pos;
    logic [7:0] m1;
    logic [7:0] pk_mag;
    logic [7:0] pk_early;
    logic [7:0] pk_late;
    logic late_pend;
    logic [2:0] pk_ang;
    logic [2:0] prev_ang;
    logic [15:0] amp_acc;
    logic [15:0] var_acc;
    logic [7:0] frq_acc;
    logic [6:0] sym_cnt;
    logic [2:0] seed_cnt;
    dsac_fsm_t fsm;
    logic ant;
    logic coherent;
    logic data_valid;
    logic cs;
    logic rx_bit;
    logic rx_stb;
    logic [1:0][15:0] rec_amp;
    logic [1:0][4:0] rec_pos;
    logic [1:0][7:0] rec_frq;
    logic [1:0] rec_ok;
    logic [7:0] nco_ph;
    logic [7:0] nco_frq;
    logic [15:0] bq;
    logic [15:0] pq;
    logic [7:0] rd_data;
  } dsac_state_s_t;

  dsac_state_s_t s;
  dsac_state_s_t n;

  logic [4:0] chips;
  logic [4:0] symlast;
  logic signed [7:0] ci [0:16];
  logic signed [7:0] cq [0:16];
  logic [7:0] ai;
  logic [7:0] aq;
  logic [7:0] mag;
  logic [2:0] ang;
  logic [2:0] dph;
  logic [2:0] cph;
  logic [2:0] e;
  logic [2:0] errsq;
  logic [15:0] amp_n;
  logic [15:0] var_n;
  logic [7:0] frq_n;
  logic present;
  logic div;
  logic other;
  logic ch;
  logic [6:0] blk_last;
  logic hit;

  always_comb begin
    case (s.rxlen[RXLEN_LSB +: 2])
      2'h0: chips = CHIPS_C0;
      2'h1: chips = CHIPS_C1;
      2'h2: chips = CHIPS_C2;
      default: chips = CHIPS_C3;
    endcase
  end
  // Two samples per chip, so one symbol spans twice the chip count.
  assign symlast = 5'({chips, 1'b0} - 6'h01);

  // Parallel matched filter: chip k sits at tap 2k, for both rails.
  assign ci[0] = 8'sh00;
  assign cq[0] = 8'sh00;
  genvar k;
  for (k = 0; k < 16; k++) begin : g_tap
    logic signed [7:0] xi;
    logic signed [7:0] xq;
    logic used;
    assign xi = 8'(s.hist[2 * k].i);
    assign xq = 8'(s.hist[2 * k].q);
    assign used = (5'(k) < chips);
    // The same receive chip drives the I and the Q rail.
    assign ci[k + 1] = !used ? ci[k] : (s.rxseq[k] ? ci[k] + xi : ci[k] - xi);
    assign cq[k + 1] = !used ? cq[k] : (s.rxseq[k] ? cq[k] + xq : cq[k] - xq);
  end

  assign ai = ci[16][7] ? 8'(-ci[16]) : 8'(ci[16]);
  assign aq = cq[16][7] ? 8'(-cq[16]) : 8'(cq[16]);
  assign mag = ai + aq;
  // Coarse angle in octants: quadrant from the signs, half from the larger rail.
  assign ang = {cq[16][7], ci[16][7] ^ cq[16][7],
                (ci[16][7] ^ cq[16][7]) ? (ai > aq) : (aq > ai)};

  // Differential reference before lock, the oscillator phase after it.
  assign dph = s.pk_ang - s.prev_ang;
  assign cph = s.pk_ang - s.nco_ph[7:5];
  assign e = s.coherent ? cph : dph;
  assign errsq = (e[1:0] == 2'h0) ? 3'h0 : ((e[1:0] == 2'h2) ? 3'h4 : 3'h1);
  assign amp_n = s.amp_acc + 16'(s.pk_mag);
  assign var_n = s.var_acc + 16'(errsq);
  assign frq_n = s.frq_acc + {{6{dph[1]}}, dph[1:0]};
  // Both measures must pass; low variance is the good direction.
  assign present = (amp_n > s.bthr) && (var_n < s.pthr);
  assign div = s.ctrl[CTRL_DIV_BIT];
  assign other = ~s.ant;
  assign ch = (div && s.rec_ok[other] && (s.rec_amp[other] > amp_n)) ? other : s.ant;
  assign blk_last = (s.fsm == ST_TRACK) ? DATA_BLOCK_LAST : ACQ_BLOCK_LAST;

  always_comb begin
    n = s;
    hit = 1'b0;
    n.rd_data = 8'h00;
    n.rx_stb = 1'b0;
    if (sample_valid) begin
      n.hist = {s.hist[30:0], sample_in};
      n.m1 = mag;
      if (s.late_pend) begin
        n.late_pend = 1'b0;
        n.pk_late = mag;
      end
      if (s.samp >= symlast) begin
        n.samp = 5'h00;
        n.pk_mag = 8'h00;
        n.prev_ang = s.pk_ang;
        n.amp_acc = amp_n;
        n.var_acc = var_n;
        n.frq_acc = frq_n;
        n.sym_cnt = s.sym_cnt + 7'h01;
        // Nearest BPSK point is zero or four octants away.
        n.rx_bit = 3'(e + 3'h2) >= 3'h4;
        n.rx_stb = s.data_valid;
        if (s.coherent) begin
          // Carrier phase is re-measured every symbol and steers the oscillator.
          n.nco_ph = s.nco_ph + s.nco_frq + {{4{e[1]}}, e[1:0], 2'b00};
          // Early/late balance nudges the on-time sample by one position.
          if (s.pk_late > s.pk_early && s.pos < 5'(symlast - 5'h01)) begin
            n.pos = s.pos + 5'h01;
          end else if (s.pk_early > s.pk_late && s.pos > 5'h01) begin
            n.pos = s.pos - 5'h01;
          end
        end
        if (s.fsm == ST_SEED) begin
          if (!s.ctrl[CTRL_DESCR_BIT] || s.seed_cnt == SEED_LAST) begin
            n.fsm = ST_TRACK;
            n.data_valid = 1'b1;
            n.sym_cnt = 7'h00;
            n.amp_acc = 16'h0000;
            n.var_acc = 16'h0000;
            n.frq_acc = 8'h00;
          end else begin
            n.seed_cnt = s.seed_cnt + 3'h1;
          end
        end
        if (s.sym_cnt >= blk_last) begin
          n.sym_cnt = 7'h00;
          n.amp_acc = 16'h0000;
          n.var_acc = 16'h0000;
          n.frq_acc = 8'h00;
          n.bq = amp_n;
          n.pq = var_n;
          n.cs = present;
          case (s.fsm)
            ST_SCAN: begin
              n.rec_amp[s.ant] = amp_n;
              n.rec_pos[s.ant] = s.pk_pos;
              n.rec_frq[s.ant] = {frq_n[6:0], 1'b0};
              n.rec_ok[s.ant] = present;
              if (present) begin
                // Scanning ends here; the better antenna is held from now on.
                n.ant = ch;
                n.pos = (ch == s.ant) ? s.pk_pos : s.rec_pos[other];
                n.nco_frq = (ch == s.ant) ? {frq_n[6:0], 1'b0} : s.rec_frq[other];
                n.nco_ph = {s.pk_ang, 5'h00};
                n.coherent = 1'b1;
                n.fsm = div ? ST_SEED : ST_VERIFY;
                n.seed_cnt = 3'h0;
                n.rec_ok = 2'b00;
              end else begin
                // Single antenna keeps dwelling on the first antenna.
                n.ant = div ? other : 1'b0;
              end
            end
            ST_VERIFY: begin
              if (present) begin
                n.fsm = ST_SEED;
              end else begin
                n.fsm = ST_SCAN;
                n.coherent = 1'b0;
              end
            end
            default: begin
              // Seeding and tracking never switch antennas.
              n.ant = s.ant;
            end
          endcase
        end
      end else begin
        n.samp = s.samp + 5'h01;
      end
      // A peak found in the symbol-end sample counts toward the next symbol.
      hit = s.coherent ? (n.samp == s.pos) : (mag > n.pk_mag);
      if (hit) begin
        n.pk_mag = mag;
        n.pk_ang = ang;
        n.pk_pos = n.samp;
        n.pk_early = s.m1;
        n.pk_late = 8'h00;
        n.late_pend = 1'b1;
      end
    end
    if (bus.wr) begin
      case (bus.addr)
        ADR_CTRL: begin
          n.ctrl = bus.wdata & 8'h03;
          if (bus.wdata[CTRL_RESTART_BIT]) begin
            n.fsm = ST_SCAN;
            n.coherent = 1'b0;
            n.data_valid = 1'b0;
            n.sym_cnt = 7'h00;
            n.rec_ok = 2'b00;
            n.amp_acc = 16'h0000;
            n.var_acc = 16'h0000;
            n.frq_acc = 8'h00;
          end
        end
        ADR_RXLEN: n.rxlen = bus.wdata & 8'hC0;
        ADR_TXLEN: n.txlen = bus.wdata & 8'h60;
        ADR_TXSEQ_A: n.txseq[15:8] = bus.wdata;
        ADR_TXSEQ_B: n.txseq[7:0] = bus.wdata;
        ADR_RXSEQ_A: n.rxseq[15:8] = bus.wdata;
        ADR_RXSEQ_B: n.rxseq[7:0] = bus.wdata;
        ADR_BTHR_A: n.bthr[15:8] = bus.wdata;
        ADR_BTHR_B: n.bthr[7:0] = bus.wdata;
        ADR_PTHR_A: n.pthr[15:8] = bus.wdata;
        ADR_PTHR_B: n.pthr[7:0] = bus.wdata;
        default: n.ctrl = s.ctrl;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        ADR_CTRL: n.rd_data = s.ctrl;
        ADR_STATUS: n.rd_data = {s.cs, s.data_valid, s.coherent, s.ant, 2'b00, s.fsm};
        ADR_RXLEN: n.rd_data = s.rxlen;
        ADR_TXLEN: n.rd_data = s.txlen;
        ADR_TXSEQ_A: n.rd_data = s.txseq[15:8];
        ADR_TXSEQ_B: n.rd_data = s.txseq[7:0];
        ADR_RXSEQ_A: n.rd_data = s.rxseq[15:8];
        ADR_RXSEQ_B: n.rd_data = s.rxseq[7:0];
        ADR_BTHR_A: n.rd_data = s.bthr[15:8];
        ADR_BTHR_B: n.rd_data = s.bthr[7:0];
        ADR_PTHR_A: n.rd_data = s.pthr[15:8];
        ADR_PTHR_B: n.rd_data = s.pthr[7:0];
        ADR_BQ_A: n.rd_data = s.bq[15:8];
        ADR_BQ_B: n.rd_data = s.bq[7:0];
        ADR_PQ_A: n.rd_data = s.pq[15:8];
        ADR_PQ_B: n.rd_data = s.pq[7:0];
        default: n.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.rxlen <= RXLEN_RST;
      s.txlen <= TXLEN_RST;
      s.txseq <= SEQ_RST;
      s.rxseq <= SEQ_RST;
      s.bthr <= BTHR_RST;
      s.pthr <= PTHR_RST;
      s.fsm <= ST_SCAN;
    end else if (ce) begin
      s <= n;
    end
  end

  assign rd_data = s.rd_data;
  assign antenna_sel = s.ant;
  assign carrier_sense_out = s.cs;
  assign coherent_mode = s.coherent;
  assign data_valid = s.data_valid;
  assign rx_bit = s.rx_bit;
  assign rx_bit_strobe = s.rx_stb;
  assign tx_spread_seq = s.txseq;
  assign tx_chip_len = s.txlen[TXLEN_LSB +: 2];

endmodule

`default_nettype wire

/* dsac_pkg.sv */
// Shared constants and types of the spread-spectrum acquisition correlator.
package dsac_pkg;

  // Register addresses on the plain register port.
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h01;
  localparam logic [7:0] ADR_RXLEN = 8'h02;
  localparam logic [7:0] ADR_TXLEN = 8'h03;
  localparam logic [7:0] ADR_TXSEQ_A = 8'h04;
  localparam logic [7:0] ADR_TXSEQ_B = 8'h05;
  localparam logic [7:0] ADR_RXSEQ_A = 8'h06;
  localparam logic [7:0] ADR_RXSEQ_B = 8'h07;
  localparam logic [7:0] ADR_BTHR_A = 8'h08;
  localparam logic [7:0] ADR_BTHR_B = 8'h09;
  localparam logic [7:0] ADR_PTHR_A = 8'h0A;
  localparam logic [7:0] ADR_PTHR_B = 8'h0B;
  localparam logic [7:0] ADR_BQ_A = 8'h0C;
  localparam logic [7:0] ADR_BQ_B = 8'h0D;
  localparam logic [7:0] ADR_PQ_A = 8'h0E;
  localparam logic [7:0] ADR_PQ_B = 8'h0F;

  // Field positions.
  localparam int CTRL_DIV_BIT = 0;
  localparam int CTRL_DESCR_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam int RXLEN_LSB = 6;
  localparam int TXLEN_LSB = 5;

  // Values after reset.
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] RXLEN_RST = 8'h00;
  localparam logic [7:0] TXLEN_RST = 8'h00;
  localparam logic [15:0] SEQ_RST = 16'h05B8;
  localparam logic [15:0] BTHR_RST = 16'h0100;
  localparam logic [15:0] PTHR_RST = 16'h0020;

  // Chip counts per symbol for the two-bit length code.
  localparam logic [4:0] CHIPS_C0 = 5'h0B;
  localparam logic [4:0] CHIPS_C1 = 5'h0D;
  localparam logic [4:0] CHIPS_C2 = 5'h0F;
  localparam logic [4:0] CHIPS_C3 = 5'h10;

  // Symbol counts.
  localparam logic [6:0] ACQ_BLOCK_LAST = 7'h0F;
  localparam logic [6:0] DATA_BLOCK_LAST = 7'h7F;
  localparam logic [2:0] SEED_LAST = 3'h6;

  typedef enum logic [1:0] {ST_SCAN, ST_VERIFY, ST_SEED, ST_TRACK} dsac_fsm_t;

  typedef struct packed {
    logic signed [2:0] i;
    logic signed [2:0] q;
  } dsac_sample_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsac_bus_t;

endpackage

/* dsac_monitor.sv */
// Concurrent checks on the ports of the acquisition correlator.
`timescale 1ns/1ps
`default_nettype none
module dsac_monitor
  import dsac_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Register port.
  input wire dsac_bus_t bus,
  input wire logic [7:0] rd_data,
  // Receiver status.
  input wire logic antenna_sel,
  input wire logic carrier_sense_out,
  input wire logic coherent_mode,
  input wire logic data_valid,
  input wire logic rx_bit_strobe,
  // Transmit set-up.
  input wire logic [15:0] tx_spread_seq,
  input wire logic [1:0] tx_chip_len
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  AST_RD_IDLE: assert property (ce && !bus.rd |=> rd_data == 8'h00)
    else $error("read data not idle");
  AST_TXLEN: assert property (ce && bus.wr && bus.addr == ADR_TXLEN
    |=> tx_chip_len == $past(bus.wdata[6:5])) else $error("tx length not stored");
  AST_TXSEQ: assert property (ce && bus.wr && bus.addr == ADR_TXSEQ_B
    |=> tx_spread_seq[7:0] == $past(bus.wdata)) else $error("tx sequence not stored");
  AST_DV_COH: assert property (data_valid |-> coherent_mode)
    else $error("data valid while differential");
  AST_SEED: assert property ($rose(coherent_mode) |-> !data_valid [*8])
    else $error("data valid without seeding");
  AST_HOLD: assert property (coherent_mode ##1 coherent_mode |-> $stable(antenna_sel))
    else $error("antenna moved while tracking");
  AST_DWELL: assert property ($changed(antenna_sel) |=> $stable(antenna_sel) [*8])
    else $error("antenna dwell too short");
  AST_CS: assert property ($rose(coherent_mode) |-> carrier_sense_out)
    else $error("acquired without carrier sense");
  AST_STROBE: assert property (rx_bit_strobe |=> !rx_bit_strobe [*8])
    else $error("symbols too close");
  cover property ($rose(coherent_mode) && antenna_sel);
  cover property ($rose(data_valid));
  cover property ($changed(antenna_sel) && !coherent_mode);
endmodule
`default_nettype wire

/* dsac_tx_model.sv */
// Remote transmitter sending a spread preamble at two samples per chip.
`timescale 1ns/1ps
`default_nettype none
module dsac_tx_model
  import dsac_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Control and antenna in use.
  input wire logic on,
  input wire logic block_first,
  input wire logic antenna_sel,
  // Samples to the receiver.
  output var dsac_sample_t smp,
  output logic smp_valid
);
  logic [4:0] idx_q;
  logic chip;
  // The last chip of a symbol is sequence bit 0, the newest correlator tap.
  assign chip = SEQ_RST[4'(5'h0A - 5'(idx_q[4:1]))];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idx_q <= '0;
      smp <= '0;
      smp_valid <= 1'b0;
    end else if (on) begin
      idx_q <= (idx_q == 5'h15) ? 5'h00 : idx_q + 5'h01;
      smp_valid <= 1'b1;
      smp.i <= (block_first && !antenna_sel) ? 3'h0 : (chip ? 3'h3 : 3'h5);
      smp.q <= 3'h0;
    end else begin
      // Between frames the lines carry a pattern that changes every cycle.
      smp_valid <= 1'b0;
      smp <= ~smp;
    end
  end
endmodule
`default_nettype wire

/* dsac_core_tb_top.sv */
// Self-checking bench of the acquisition correlator with a remote transmitter.
`timescale 1ns/1ps
`default_nettype none
module dsac_core_tb_top;
  import dsac_pkg::*;
  localparam int SYM = 22;
  localparam int DW = 16 * SYM;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic on = 1'b0;
  logic blk = 1'b0;
  dsac_bus_t bus = '0;
  dsac_sample_t smp;
  logic smp_valid, ant, cs, coh, dv, rx_bit, strobe;
  logic [7:0] rd_data;
  logic [15:0] tx_seq;
  logic [1:0] tx_len;
  int n_errors = 0;
  int checked = 0;
  initial begin
    forever #2 clock = ~clock;
  end
  dsac_core DUT (.clock(clock), .rst(rst), .ce(ce), .bus(bus), .rd_data(rd_data),
    .sample_in(smp), .sample_valid(smp_valid), .antenna_sel(ant), .carrier_sense_out(cs),
    .coherent_mode(coh), .data_valid(dv), .rx_bit(rx_bit), .rx_bit_strobe(strobe),
    .tx_spread_seq(tx_seq), .tx_chip_len(tx_len));
  dsac_tx_model u_tx (.clock(clock), .rst(rst), .on(on), .block_first(blk),
    .antenna_sel(ant), .smp(smp), .smp_valid(smp_valid));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr_c(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    bus <= '0;
  endtask
  task automatic rd_c(input string nm, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
    @(posedge clock);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    bus <= '0;
    #1;
    chk(nm, {8'h00, rd_data & m}, {8'h00, e});
  endtask
  task automatic restart_dut(input logic [7:0] ctrl, input logic b);
    @(posedge clock);
    on <= 1'b0;
    blk <= b;
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    wr_c(ADR_CTRL, ctrl);
  endtask
  task automatic t_regs();
    restart_dut(CTRL_RST, 1'b0);
    rd_c("ctrl", ADR_CTRL, 8'hFF, CTRL_RST);
    rd_c("rxseq", ADR_RXSEQ_A, 8'hFF, SEQ_RST[15:8]);
    rd_c("bthr", ADR_BTHR_B, 8'hFF, BTHR_RST[7:0]);
    rd_c("pthr", ADR_PTHR_B, 8'hFF, PTHR_RST[7:0]);
    rd_c("unmapped", 8'h40, 8'hFF, 8'h00);
    chk("txseq_rst", tx_seq, SEQ_RST);
    wr_c(ADR_TXSEQ_A, 8'h3C);
    wr_c(ADR_TXSEQ_B, 8'hA1);
    wr_c(ADR_TXLEN, 8'hFF);
    rd_c("rx_kept", ADR_RXSEQ_B, 8'hFF, SEQ_RST[7:0]);
    chk("txseq", tx_seq, 16'h3CA1);
    chk("txlen", {14'h0000, tx_len}, 16'h0003);
    rd_c("txlen", ADR_TXLEN, 8'hFF, 8'h60);
    for (int c = 0; c < 4; c++) begin
      wr_c(ADR_RXLEN, {2'(c), 6'h3F});
      rd_c("rxlen", ADR_RXLEN, 8'hFF, {2'(c), 6'h00});
    end
    wr_c(ADR_STATUS, 8'hFF);
    rd_c("status_ro", ADR_STATUS, 8'hFF, 8'h00);
    // A write while the enable is low must leave every register frozen.
    @(posedge clock);
    ce <= 1'b0;
    wr_c(ADR_TXSEQ_A, 8'h55);
    ce <= 1'b1;
    cyc(1);
    chk("ce_hold", tx_seq, 16'h3CA1);
  endtask
  task automatic t_and();
    restart_dut(CTRL_RST, 1'b0);
    wr_c(ADR_PTHR_B, 8'h00);
    on <= 1'b1;
    cyc(DW + 8);
    chk("ant_d1", ant, 1'b1);
    chk("cs_and", cs, 1'b0);
    cyc(DW);
    chk("ant_d2", ant, 1'b0);
    chk("coh_and", coh, 1'b0);
  endtask
  task automatic t_div();
    int n_stb = 0;
    restart_dut(CTRL_RST, 1'b1);
    on <= 1'b1;
    cyc(DW + 8);
    chk("ant_scan", ant, 1'b1);
    chk("coh_scan", coh, 1'b0);
    cyc(DW + 40 * SYM);
    chk("cs", cs, 1'b1);
    rd_c("status", ADR_STATUS, 8'h33, 8'h33);
    // The preamble never changes phase, so each coherent decision is the zero-phase bit.
    repeat (4 * SYM) begin
      cyc(1);
      if (strobe === 1'b1) begin
        n_stb++;
        chk("rx_bit", rx_bit, 1'b0);
      end
    end
    chk("strobes", n_stb[15:0], 16'h0004);
  endtask
  task automatic t_descr();
    restart_dut(8'h03, 1'b0);
    on <= 1'b1;
    // Probe half a symbol either side of the seventh seeding symbol end.
    cyc(DW + 6 * SYM + 12);
    chk("coh", coh, 1'b1);
    chk("dv_seed", dv, 1'b0);
    cyc(SYM);
    chk("dv", dv, 1'b1);
  endtask
  task automatic t_single();
    restart_dut(8'h00, 1'b0);
    wr_c(ADR_BTHR_A, 8'h00);
    wr_c(ADR_PTHR_A, 8'hFF);
    on <= 1'b1;
    cyc(DW + 8);
    rd_c("verify", ADR_STATUS, 8'h33, 8'h21);
    cyc(DW);
    chk("coh_single", coh, 1'b1);
    chk("ant_single", ant, 1'b0);
  endtask
  initial begin
    t_regs();
    t_and();
    t_div();
    t_descr();
    t_single();
    results();
  end
endmodule
bind dsac_core dsac_monitor u_mon (.clock(clock), .rst(rst), .ce(ce), .bus(bus),
  .rd_data(rd_data), .antenna_sel(antenna_sel), .carrier_sense_out(carrier_sense_out),
  .coherent_mode(coherent_mode), .data_valid(data_valid), .rx_bit_strobe(rx_bit_strobe),
  .tx_spread_seq(tx_spread_seq), .tx_chip_len(tx_chip_len));
`default_nettype wire
